// ==== hw/gpio_port_map.svh ====
// constants for the four pin port: widths, select codes, reset values
// assumes inclusion by the port package and the four pin port module
`ifndef GPIO_PORT_MAP_SVH
`define GPIO_PORT_MAP_SVH

`define PORT_W       4
`define SYNC_W       8
`define CFG_SEL_W    3
`define ZERO_NIB     4'h0

`define CFG_SEL_DIR  3'h0
`define CFG_SEL_OD   3'h1
`define CFG_SEL_SLEW 3'h2
`define CFG_SEL_THR  3'h3
`define CFG_SEL_ANA  3'h4
`define CFG_SEL_PSEL 3'h5

`define DIR_RST      4'hF
`define LAT_RST      4'h0
`define OD_RST       4'h0
`define SLEW_RST     4'hF
`define THR_RST      4'hF
`define ANA_RST      4'hF
`define PSEL_RST     4'h0

`endif

// ==== hw/gpio_port_pkg.sv ====
// types shared by the four pin port modules
// assumes the constant header is on the include path
`include "gpio_port_map.svh"

package gpio_port_pkg;

	typedef logic [`PORT_W-1:0] nib_t;
	typedef logic [`SYNC_W-1:0] sync_t;

	typedef enum logic [`CFG_SEL_W-1:0] {
		SEL_DIR  = `CFG_SEL_DIR,
		SEL_OD   = `CFG_SEL_OD,
		SEL_SLEW = `CFG_SEL_SLEW,
		SEL_THR  = `CFG_SEL_THR,
		SEL_ANA  = `CFG_SEL_ANA,
		SEL_PSEL = `CFG_SEL_PSEL
	} cfg_sel_t;

endpackage : gpio_port_pkg

// ==== hw/pin_input_sync.sv ====
// two flop synchroniser for the raw pad comparator outputs
// assumes raw inputs are asynchronous to the core clock
`timescale 1ns/10ps

module pin_input_sync
	import gpio_port_pkg::*;
(
	input  wire logic  clk,
	input  wire logic  rst_n,
	input  wire sync_t raw_in,
	output sync_t      sync_out
);

	sync_t meta_q;
	sync_t hold_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			hold_q <= '0;
		end else begin
			meta_q <= raw_in;
			hold_q <= meta_q;
		end
	end

	assign sync_out = hold_q;

endmodule : pin_input_sync

// ==== hw/four_pin_gpio_port.sv ====
// four pin general purpose port: latch, direction, drive and input paths
// assumes pad comparators, analog switches and a pin routing block outside
`timescale 1ns/10ps
`include "gpio_port_map.svh"

module four_pin_gpio_port
	import gpio_port_pkg::*;
(
	input  wire logic     CORE_CLK,
	input  wire logic     RST_N,
	input  wire nib_t     PIN_IN_ST,
	input  wire nib_t     PIN_IN_TTL,
	output nib_t          PIN_OUT,
	output nib_t          PIN_OE,
	output nib_t          PIN_SLEW_LIMIT,
	output nib_t          ANALOG_EN,
	input  wire logic     PORT_WR,
	input  wire nib_t     PORT_WDATA,
	input  wire nib_t     PORT_WMASK,
	output nib_t          PORT_RDATA,
	input  wire logic     LAT_WR,
	input  wire nib_t     LAT_WDATA,
	input  wire nib_t     LAT_WMASK,
	output nib_t          LAT_RDATA,
	input  wire logic     CFG_WR,
	input  wire cfg_sel_t CFG_SEL,
	input  wire nib_t     CFG_WDATA,
	output nib_t          CFG_RDATA,
	input  wire nib_t     PERIPH_OUT_DATA,
	output nib_t          PERIPH_IN,
	output nib_t          PIN_CHANGE
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic nib_t merge_bits(nib_t base, nib_t upd, nib_t mask);
		merge_bits = (upd & mask) | (base & ~mask);
	endfunction : merge_bits

	////////////////////////////////////////////////////////////////////////
	// input path

	sync_t sync_all;
	nib_t  sync_st;
	nib_t  sync_ttl;
	nib_t  dig_in;
	nib_t  pin_rd;

	pin_input_sync u_sync (
		.clk      (CORE_CLK),
		.rst_n    (RST_N),
		.raw_in   ({PIN_IN_TTL, PIN_IN_ST}),
		.sync_out (sync_all)
	);

	nib_t dir_q;
	nib_t lat_q;
	nib_t lat_d;
	nib_t od_q;
	nib_t slew_q;
	nib_t thr_q;
	nib_t ana_q;
	nib_t psel_q;
	nib_t rd_q;
	nib_t chg_q;
	nib_t out_q;
	nib_t out_d;
	nib_t oe_q;
	nib_t oe_d;
	nib_t cfg_rd_q;
	nib_t cfg_rd_d;
	nib_t src;

	assign sync_st  = sync_all[`PORT_W-1:0];
	assign sync_ttl = sync_all[`SYNC_W-1:`PORT_W];
	// threshold bit set picks Schmitt, clear picks TTL
	assign dig_in = (thr_q & sync_st) | (~thr_q & sync_ttl);
	assign pin_rd = dig_in & ~ana_q;

	////////////////////////////////////////////////////////////////////////
	// latch and configuration

	// a data write merges into sampled pins; it wins over a latch write
	assign lat_d = PORT_WR ? merge_bits(pin_rd, PORT_WDATA, PORT_WMASK)
		: LAT_WR ? merge_bits(lat_q, LAT_WDATA, LAT_WMASK) : lat_q;

	wire wr_dir  = CFG_WR && (CFG_SEL == SEL_DIR);
	wire wr_od   = CFG_WR && (CFG_SEL == SEL_OD);
	wire wr_slew = CFG_WR && (CFG_SEL == SEL_SLEW);
	wire wr_thr  = CFG_WR && (CFG_SEL == SEL_THR);
	wire wr_ana  = CFG_WR && (CFG_SEL == SEL_ANA);
	wire wr_psel = CFG_WR && (CFG_SEL == SEL_PSEL);

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			lat_q  <= `LAT_RST;
			dir_q  <= `DIR_RST;
			od_q   <= `OD_RST;
			slew_q <= `SLEW_RST;
			thr_q  <= `THR_RST;
			ana_q  <= `ANA_RST;
			psel_q <= `PSEL_RST;
		end else begin
			lat_q <= lat_d;
			if (wr_dir) dir_q <= CFG_WDATA;
			if (wr_od) od_q <= CFG_WDATA;
			if (wr_slew) slew_q <= CFG_WDATA;
			if (wr_thr) thr_q <= CFG_WDATA;
			if (wr_ana) ana_q <= CFG_WDATA;
			if (wr_psel) psel_q <= CFG_WDATA;
		end
	end

	always_comb begin
		unique case (CFG_SEL)
			SEL_DIR:  cfg_rd_d = dir_q;
			SEL_OD:   cfg_rd_d = od_q;
			SEL_SLEW: cfg_rd_d = slew_q;
			SEL_THR:  cfg_rd_d = thr_q;
			SEL_ANA:  cfg_rd_d = ana_q;
			SEL_PSEL: cfg_rd_d = psel_q;
			default:  cfg_rd_d = `ZERO_NIB;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// output drive

	// routed peripheral data replaces the latch only where selected
	assign src = (psel_q & PERIPH_OUT_DATA) | (~psel_q & lat_q);
	// analog select plays no part in the drive
	assign oe_d  = ~dir_q & ~(od_q & src);
	assign out_d = src & ~od_q;

	////////////////////////////////////////////////////////////////////////
	// sampled state

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			out_q    <= `ZERO_NIB;
			oe_q     <= `ZERO_NIB;
			rd_q     <= `ZERO_NIB;
			chg_q    <= `ZERO_NIB;
			cfg_rd_q <= `ZERO_NIB;
		end else begin
			out_q    <= out_d;
			oe_q     <= oe_d;
			rd_q     <= pin_rd;
			// threshold edits can fake an edge here
			chg_q    <= pin_rd ^ rd_q;
			cfg_rd_q <= cfg_rd_d;
		end
	end

	assign PIN_OUT        = out_q;
	assign PIN_OE         = oe_q;
	assign PIN_SLEW_LIMIT = slew_q;
	assign ANALOG_EN      = ana_q;
	assign PORT_RDATA     = rd_q;
	assign PERIPH_IN      = rd_q;
	assign LAT_RDATA      = lat_q;
	assign CFG_RDATA      = cfg_rd_q;
	assign PIN_CHANGE     = chg_q;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	AST_DIR_HIZ: assert property (
		(PIN_OE & $past(dir_q)) == `ZERO_NIB)
		else $error("driver enabled on an input pin");

	AST_DRIVE_LAT: assert property (
		((PIN_OUT ^ $past(lat_q)) & $past(~dir_q & ~od_q & ~psel_q))
		== `ZERO_NIB)
		else $error("pin does not carry the latch");

	AST_PERIPH_DRIVE: assert property (
		((PIN_OUT ^ $past(PERIPH_OUT_DATA)) & $past(~dir_q & ~od_q & psel_q))
		== `ZERO_NIB)
		else $error("routed pin does not carry peripheral data");

	AST_OD_NO_HIGH: assert property (
		(PIN_OE & PIN_OUT & $past(od_q)) == `ZERO_NIB)
		else $error("open drain pin driven high");

	AST_ANALOG_ZERO: assert property (
		(PORT_RDATA & $past(ana_q)) == `ZERO_NIB)
		else $error("analog pin reads nonzero");

	AST_ANALOG_DRIVES: assert property (
		($past(~dir_q & ~od_q) & ~PIN_OE) == `ZERO_NIB)
		else $error("push pull output pin not driven");

	AST_THRESH_ST: assert property (
		((PORT_RDATA ^ $past(sync_st)) & $past(thr_q & ~ana_q)) == `ZERO_NIB)
		else $error("Schmitt pin read does not follow its comparator");

	AST_RMW: assert property (
		PORT_WR |=> LAT_RDATA == merge_bits($past(pin_rd),
			$past(PORT_WDATA), $past(PORT_WMASK)))
		else $error("data write did not merge into sampled pins");

	AST_LAT_HOLD: assert property (
		(!PORT_WR && !LAT_WR) |=> $stable(LAT_RDATA))
		else $error("latch changed without a write");

endmodule : four_pin_gpio_port

// ==== test/pin_far_side.sv ====
// far side of the port: pad wire resolution and both input comparators
// assumes a pull-up on every pin; the port driver beats the outside one
`timescale 1ns/10ps

module pin_far_side
	import gpio_port_pkg::*;
(
	input  wire nib_t pin_out,
	input  wire nib_t pin_oe,
	input  wire nib_t drv_val,
	input  wire nib_t drv_en,
	input  wire nib_t ttl_skew,
	output nib_t      st_lvl,
	output nib_t      ttl_lvl
);
	// port drive, else outside drive, else pull-up
	wire nib_t pad = (pin_oe & pin_out) | (~pin_oe & drv_en & drv_val)
		| (~pin_oe & ~drv_en);
	assign st_lvl  = pad;
	// mid-level pads where the two thresholds disagree
	assign ttl_lvl = pad ^ ttl_skew;
endmodule : pin_far_side

// ==== test/test_four_pin_gpio_port.sv ====
// self-checking bench for the four pin port
// assumes the port package and the far side pad model
`timescale 1ns/10ps

module test_four_pin_gpio_port
	import gpio_port_pkg::*;
;
	logic     clk, rst_n, pwr, lwr, cwr;
	cfg_sel_t sel;
	nib_t     pwd, pwm, lwd, lwm, cwd, per, dv, de, sk;
	nib_t     st, ttl, po, poe, slw, ana, prd, lrd, crd, pin, pchg;
	nib_t     chg_val, chg_cnt;
	int       failures, samples_checked, i;
	nib_t     rst_cfg [8] = '{4'hF, 4'h0, 4'hF, 4'hF, 4'hF, 4'h0, 4'h0, 4'h0};

	four_pin_gpio_port four_pin_gpio_port_inst (
		.CORE_CLK(clk), .RST_N(rst_n), .PIN_IN_ST(st), .PIN_IN_TTL(ttl),
		.PIN_OUT(po), .PIN_OE(poe), .PIN_SLEW_LIMIT(slw), .ANALOG_EN(ana),
		.PORT_WR(pwr), .PORT_WDATA(pwd), .PORT_WMASK(pwm), .PORT_RDATA(prd),
		.LAT_WR(lwr), .LAT_WDATA(lwd), .LAT_WMASK(lwm), .LAT_RDATA(lrd),
		.CFG_WR(cwr), .CFG_SEL(sel), .CFG_WDATA(cwd), .CFG_RDATA(crd),
		.PERIPH_OUT_DATA(per), .PERIPH_IN(pin), .PIN_CHANGE(pchg));
	pin_far_side pin_far_side_inst (.pin_out(po), .pin_oe(poe),
		.drv_val(dv), .drv_en(de), .ttl_skew(sk), .st_lvl(st), .ttl_lvl(ttl));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// remembers the last change pulse and how many cycles carried one
	always @(posedge clk) begin
		if (!rst_n) begin
			chg_cnt <= 4'h0;
			chg_val <= 4'h0;
		end else if (pchg != 4'h0) begin
			chg_cnt <= chg_cnt + 4'h1;
			chg_val <= pchg;
		end
	end
	////////////////////////////////////////////////////////////////////////
	task settle;
		repeat (4) @(posedge clk);
		#1;
	endtask : settle
	task chk(input nib_t got, input nib_t exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task cfg(input int s, input nib_t v);
		@(posedge clk);
		sel <= cfg_sel_t'(s);
		cwd <= v;
		cwr <= 1'b1;
		@(posedge clk);
		cwr <= 1'b0;
		settle;
	endtask : cfg
	// k 1 writes the latch, k 0 the data register
	task wr(input int k, input nib_t v, input nib_t m);
		@(posedge clk);
		{pwd, pwm, lwd, lwm} <= {v, m, v, m};
		if (k == 1) lwr <= 1'b1;
		else pwr <= 1'b1;
		@(posedge clk);
		{pwr, lwr} <= 2'b00;
		settle;
	endtask : wr
	task print_verdict;
		$display("checked %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3000) @(posedge clk);
		failures++;
		print_verdict;
	end
	initial begin
		{rst_n, pwr, lwr, cwr} = '0;
		sel = SEL_DIR;
		{pwd, pwm, lwd, lwm, cwd, per, dv, de, sk} = '0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		settle;
		chk(poe, 4'h0);
		chk(ana, 4'hF);
		for (i = 0; i < 8; i++) begin
			@(posedge clk);
			sel <= cfg_sel_t'(i);
			settle;
			chk(crd, rst_cfg[i]);
		end
		$display("test reset done");
		@(posedge clk);
		{de, dv} <= {4'hF, 4'h5};
		settle;
		chk(prd, 4'h0);
		cfg(4, 4'h0);
		chk(prd, 4'h5);
		chk(chg_cnt, 4'h1);
		chk(chg_val, 4'h5);
		@(posedge clk);
		sk <= 4'h3;
		settle;
		chk(prd, 4'h5);
		cfg(3, 4'h0);
		chk(prd, 4'h6);
		chk(pin, 4'h6);
		chk(chg_cnt, 4'h2);
		chk(chg_val, 4'h3);
		cfg(3, 4'hF);
		$display("test inputs done");
		wr(1, 4'hA, 4'hF);
		chk(lrd, 4'hA);
		chk(prd, 4'h5);
		cfg(0, 4'hC);
		chk(poe, 4'h3);
		chk(po, 4'hA);
		chk(prd, 4'h6);
		wr(0, 4'h1, 4'h1);
		chk(lrd, 4'h7);
		chk(po, 4'h7);
		wr(1, 4'h0, 4'h0);
		chk(lrd, 4'h7);
		$display("test data done");
		cfg(0, 4'h0);
		cfg(1, 4'hF);
		chk(poe, 4'h8);
		chk(po, 4'h0);
		cfg(1, 4'h0);
		cfg(2, 4'h5);
		chk(slw, 4'h5);
		cfg(4, 4'hF);
		chk(poe, 4'hF);
		chk(po, 4'h7);
		chk(prd, 4'h0);
		@(posedge clk);
		per <= 4'h9;
		cfg(5, 4'hF);
		chk(po, 4'h9);
		$display("test drive done");
		print_verdict;
	end
endmodule : test_four_pin_gpio_port
